/* include/lesp_pkg.sv */
// Purpose: constants for the serial port sync and routing register bank
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package lesp_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_UPDATE_HOLD = 12'h040;
  localparam logic [11:0] OFS_SYNC_BUSY = 12'h044;
  localparam logic [11:0] OFS_PIN_ENABLE = 12'h054;
  localparam logic [11:0] OFS_PIN_LOCATION = 12'h058;
  localparam logic [11:0] OFS_RX_SOURCE = 12'h064;
  // staged core registers, offsets chosen for this bank
  localparam logic [11:0] OFS_STAGE_BASE = 12'h080;
  localparam int unsigned NUM_SYNC = 8;
  // busy bit positions
  localparam int unsigned BIT_CTRL = 0;
  localparam int unsigned BIT_CMD = 1;
  localparam int unsigned BIT_CLOCK_DIVIDER_BUSY = 2;
  localparam int unsigned BIT_START_FRAME_BUSY = 3;
  localparam int unsigned BIT_SIGNAL_FRAME_BUSY = 4;
  localparam int unsigned BIT_TRANSMIT_DATA_BUSY_EXT = 5;
  localparam int unsigned BIT_TRANSMIT_DATA_BUSY = 6;
  localparam int unsigned BIT_PULSE = 7;
  // field positions
  localparam int unsigned POS_HOLD = 0;
  localparam int unsigned POS_RX_PEN = 0;
  localparam int unsigned POS_TX_PEN = 1;
  localparam int unsigned POS_RX_LOC = 0;
  localparam int unsigned POS_TX_LOC = 8;
  localparam int unsigned LOC_W = 6;
  localparam int unsigned POS_EV_CH = 0;
  localparam int unsigned EV_CH_W = 4;
  localparam int unsigned POS_EV_EN = 5;
  localparam int unsigned NUM_EV_CH = 16;
  localparam logic [31:0] RST_VALUE = 32'h0000_0000;
  // synchroniser length in low-frequency clock ticks
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  typedef enum logic [1:0] {LESP_IDLE, LESP_WAIT, LESP_ACK} lesp_sync_st_t;
endpackage

/* design/lesp_sync_slot.sv */
// Purpose: carries one staged register value into the low-frequency domain
// Assumes: lf_tick is a one-cycle pulse per low-frequency clock edge
// Notes: busy stays high from write until the value lands
`timescale 1ns/1ps
module lesp_sync_slot
  import lesp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cen,
  input wire logic wr,
  input wire logic [31:0] wdata,
  input wire logic hold,
  input wire logic lf_tick,
  output logic busy,
  output logic [31:0] lf_value
);
  lesp_sync_st_t st_q, st_d;
  logic [31:0] stage_q, stage_d, lf_q, lf_d;
  logic [1:0] cnt_q, cnt_d;

  always_comb begin
    st_d = st_q;
    stage_d = stage_q;
    lf_d = lf_q;
    cnt_d = cnt_q;
    if (wr) begin
      stage_d = wdata;
    end
    case (st_q)
      LESP_IDLE: begin
        if (wr) begin
          st_d = LESP_WAIT;
        end
      end
      LESP_WAIT: begin
        // held values stay pending until hold drops
        if (!hold) begin
          st_d = LESP_ACK;
          cnt_d = 2'h0;
        end
      end
      LESP_ACK: begin
        // a hold raised mid-flight sends the value back to wait, so nothing lands under hold
        if (hold) begin
          st_d = LESP_WAIT;
        end else if (lf_tick) begin
          cnt_d = cnt_q + 2'h1;
          if (cnt_q + 2'h1 == SYNC_TICKS) begin
            lf_d = stage_q;
            st_d = wr ? LESP_WAIT : LESP_IDLE;
          end
        end
      end
      default: st_d = LESP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= LESP_IDLE;
      stage_q <= RST_VALUE;
      lf_q <= RST_VALUE;
      cnt_q <= 2'h0;
    end else if (cen) begin
      st_q <= st_d;
      stage_q <= stage_d;
      lf_q <= lf_d;
      cnt_q <= cnt_d;
    end
  end

  assign busy = (st_q != LESP_IDLE);
  assign lf_value = lf_q;

  // assertions
  sequence s_released;
    cen && st_q == LESP_WAIT && !hold;
  endsequence

  sequence s_landing;
    cen && st_q == LESP_ACK && !hold && lf_tick && (cnt_q + 2'h1 == SYNC_TICKS);
  endsequence

  property p_free_apply;
    @(posedge pclk) disable iff (!presetn)
      s_released |=> st_q == LESP_ACK;
  endproperty
  a_free_apply: assert property (p_free_apply) else $error("free update stalled");

  property p_land;
    @(posedge pclk) disable iff (!presetn)
      s_landing |=> lf_q == $past(stage_q);
  endproperty
  a_land: assert property (p_land) else $error("staged value not applied");
endmodule

/* design/lesp_regs.sv */
// Purpose: APB register bank for update hold, sync busy, pin routing, rx source
// Assumes: lf_tick marks low-frequency clock edges, synchronous to pclk
// Notes: zero-wait APB slave; unmapped addresses read zero, no error
// Overview of operation
// - with hold clear, each write is carried to the low-frequency side after SYNC_TICKS (two) lf_tick pulses
// - with hold set, new values wait and all apply together on release
// - eight read-only busy flags, high while a register value synchronises
// - six-bit transmit location at bits 13:8 picks output location
// - six-bit receive location at bits 5:0 picks input location
// - event enable bit 5 takes receive from event channel in bits 3:0
`timescale 1ns/1ps
module lesp_regs
  import lesp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cen,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lesp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lf_tick,
  input wire logic core_tx,
  output logic serial_transmit_pin_o,
  output logic serial_transmit_pin_oe,
  output logic [5:0] tx_location,
  input wire logic [63:0] serial_receive_pin_i,
  input wire logic [15:0] event_routing_channel,
  output logic core_rx,
  output logic [255:0] lf_values
);
  import lesp_pkg::*;

  logic hold_q, hold_d;
  logic [1:0] pen_q, pen_d;
  logic [13:0] loc_q, loc_d;
  logic [5:0] src_q, src_d;
  logic [31:0] rdata_q, rdata_d;
  logic [NUM_SYNC-1:0] busy;
  logic [NUM_SYNC-1:0] slot_wr;
  logic wr_en;
  logic rd_en;
  logic rx_pin_sel;

  function automatic logic [31:0] word_at(input logic [11:0] ofs, input logic [11:0] a);
    word_at = {31'h0, (a == ofs)};
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_comb begin
    hold_d = hold_q;
    pen_d = pen_q;
    loc_d = loc_q;
    src_d = src_q;
    rdata_d = rdata_q;
    if (wr_en) begin
      if (word_at(OFS_UPDATE_HOLD, paddr) != 32'h0) hold_d = pwdata[POS_HOLD];
      if (word_at(OFS_PIN_ENABLE, paddr) != 32'h0) pen_d = pwdata[1:0];
      if (word_at(OFS_PIN_LOCATION, paddr) != 32'h0) begin
        loc_d = {pwdata[POS_TX_LOC +: LOC_W], 2'h0, pwdata[POS_RX_LOC +: LOC_W]};
      end
      if (word_at(OFS_RX_SOURCE, paddr) != 32'h0) begin
        src_d = {pwdata[POS_EV_EN], 1'h0, pwdata[POS_EV_CH +: EV_CH_W]};
      end
    end
    if (rd_en) begin
      case (paddr)
        OFS_UPDATE_HOLD: rdata_d = {31'h0, hold_q};
        OFS_SYNC_BUSY: rdata_d = {24'h0, busy};
        OFS_PIN_ENABLE: rdata_d = {30'h0, pen_q};
        OFS_PIN_LOCATION: rdata_d = {18'h0, loc_q};
        OFS_RX_SOURCE: rdata_d = {26'h0, src_q};
        default: rdata_d = 32'h0;
      endcase
      if (paddr >= OFS_STAGE_BASE && paddr < OFS_STAGE_BASE + 12'h020) begin
        rdata_d = lf_values[{paddr[4:2], 5'h0} +: 32];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
      pen_q <= 2'h0;
      loc_q <= 14'h0;
      src_q <= 6'h0;
      rdata_q <= RST_VALUE;
    end else if (cen) begin
      hold_q <= hold_d;
      pen_q <= pen_d;
      loc_q <= loc_d;
      src_q <= src_d;
      rdata_q <= rdata_d;
    end
  end

  // staged core registers, one word each, busy bit order
  genvar g;
  generate
    for (g = 0; g < NUM_SYNC; g++) begin : g_slot
      assign slot_wr[g] = wr_en && paddr == OFS_STAGE_BASE + 12'(4 * g);
      lesp_sync_slot u_slot (
        .pclk(pclk),
        .presetn(presetn),
        .cen(cen),
        .wr(slot_wr[g]),
        .wdata(pwdata),
        .hold(hold_q),
        .lf_tick(lf_tick),
        .busy(busy[g]),
        .lf_value(lf_values[32*g +: 32])
      );
    end
  endgenerate

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rdata_q;

  assign serial_transmit_pin_oe = pen_q[POS_TX_PEN];
  assign serial_transmit_pin_o = pen_q[POS_TX_PEN] & core_tx;
  assign tx_location = loc_q[13:8];
  // locations 0 to 63 each pick one of the 64 serial_receive_pin_i inputs
  assign rx_pin_sel = serial_receive_pin_i[loc_q[5:0]];
  always_comb begin
    if (src_q[POS_EV_EN]) begin
      core_rx = event_routing_channel[src_q[3:0]];
    end else if (pen_q[POS_RX_PEN]) begin
      core_rx = rx_pin_sel;
    end else begin
      core_rx = 1'b1;
    end
  end

  // assertions
  property p_hold_blocks;
    @(posedge pclk) disable iff (!presetn)
      (cen && hold_q && busy[0] && lf_tick) |=> $stable(lf_values[31:0]);
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) else $error("value applied under hold");

  property p_busy_on_write;
    @(posedge pclk) disable iff (!presetn)
      (cen && slot_wr[1]) |=> busy[1];
  endproperty
  a_busy_on_write: assert property (p_busy_on_write) else $error("busy not raised");

  property p_tx_off;
    @(posedge pclk) disable iff (!presetn)
      !pen_q[1] |-> !serial_transmit_pin_oe && !serial_transmit_pin_o;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx driven while disabled");

  property p_rx_off;
    @(posedge pclk) disable iff (!presetn)
      (!pen_q[0] && !src_q[5]) |-> core_rx;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx connected while disabled");

  property p_tx_loc;
    @(posedge pclk) disable iff (!presetn)
      (cen && wr_en && paddr == OFS_PIN_LOCATION) |=> tx_location == $past(pwdata[13:8]);
  endproperty
  a_tx_loc: assert property (p_tx_loc) else $error("tx location wrong");

  property p_rx_loc;
    @(posedge pclk) disable iff (!presetn)
      (pen_q[0] && !src_q[5]) |-> core_rx == serial_receive_pin_i[loc_q[5:0]];
  endproperty
  a_rx_loc: assert property (p_rx_loc) else $error("rx location wrong");

  property p_event_rx;
    @(posedge pclk) disable iff (!presetn)
      src_q[5] |-> core_rx == event_routing_channel[src_q[3:0]];
  endproperty
  a_event_rx: assert property (p_event_rx) else $error("event source wrong");

  property p_pen_write;
    @(posedge pclk) disable iff (!presetn)
      (cen && wr_en && paddr == OFS_PIN_ENABLE) |=> pen_q == $past(pwdata[1:0]);
  endproperty
  a_pen_write: assert property (p_pen_write) else $error("pin enable not written");
endmodule

/* bench/lesp_regs_test.sv */
// Purpose: self-checking bench for the sync and routing register bank
// Assumes: zero-wait APB slave, lf_tick pulses driven by the bench
// Notes: plain register cases run from a table, sync and reset by hand
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module lesp_regs_test;
  import lesp_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} lesp_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic lf_tick = 1'b0;
  logic core_tx = 1'b0;
  logic [63:0] rx_pins = 64'h0;
  logic [15:0] ev_ch = 16'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic tx_o;
  logic tx_oe;
  logic [5:0] tx_loc;
  logic core_rx;
  logic [255:0] lf_values;
  int error_cnt = 0;
  int cmp_count = 0;
  lesp_row_t rows [7] = '{'{OFS_PIN_ENABLE, 32'h3, 32'h3},
    '{OFS_PIN_LOCATION, 32'h1f1f, 32'h1f1f}, '{OFS_RX_SOURCE, 32'h2f, 32'h2f},
    '{OFS_UPDATE_HOLD, 32'h1, 32'h1}, '{OFS_UPDATE_HOLD, 32'h0, 32'h0},
    '{OFS_SYNC_BUSY, 32'hff, 32'h0}, '{12'h0fc, 32'hdead_beef, 32'h0}};

  lesp_regs u_dut (.pclk(pclk), .presetn(presetn), .cen(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lf_tick(lf_tick),
    .core_tx(core_tx), .serial_transmit_pin_o(tx_o), .serial_transmit_pin_oe(tx_oe),
    .tx_location(tx_loc), .serial_receive_pin_i(rx_pins),
    .event_routing_channel(ev_ch), .core_rx(core_rx), .lf_values(lf_values));

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // entered just after a rising edge, leaves just after one
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      close_out();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic lf_pulse(input int n);
    repeat (n) begin
      lf_tick <= 1'b1;
      @(posedge pclk);
      lf_tick <= 1'b0;
      @(posedge pclk);
    end
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      `CHK(rd, rows[i].e)
    end
    `CHK(pslverr, 1'b0)
    // pins on, tx location 31, rx from event channel 15
    core_tx <= 1'b1;
    ev_ch <= 16'h8000;
    @(negedge pclk);
    `CHK({tx_oe, tx_o, tx_loc, core_rx}, 9'h1bf)
    @(posedge pclk);
    core_tx <= 1'b0;
    ev_ch <= 16'h7fff;
    @(negedge pclk);
    `CHK({tx_o, core_rx}, 2'b00)
    @(posedge pclk);
    apb(1'b1, OFS_RX_SOURCE, 32'h0f);
    rx_pins <= 64'h0000_0000_8000_0000;
    @(negedge pclk);
    `CHK(core_rx, 1'b1)
    @(posedge pclk);
    rx_pins <= 64'hffff_ffff_7fff_ffff;
    @(negedge pclk);
    `CHK(core_rx, 1'b0)
    @(posedge pclk);
    apb(1'b1, OFS_PIN_ENABLE, 32'h0);
    core_tx <= 1'b1;
    @(negedge pclk);
    `CHK({tx_oe, tx_o, core_rx}, 3'b001)
    // asynchronous reset mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_PIN_LOCATION, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, OFS_RX_SOURCE, 32'h0);
    `CHK(rd, 32'h0)
    // free-running update of the command slot
    apb(1'b1, OFS_STAGE_BASE + 12'h004, 32'ha5);
    apb(1'b0, OFS_SYNC_BUSY, 32'h0);
    `CHK(rd, 32'h2)
    lf_pulse(int'(SYNC_TICKS));
    apb(1'b0, OFS_SYNC_BUSY, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(lf_values[63:32], 32'ha5)
    // held update of control and clock divider slots
    apb(1'b1, OFS_UPDATE_HOLD, 32'h1);
    apb(1'b1, OFS_STAGE_BASE, 32'h11);
    apb(1'b1, OFS_STAGE_BASE + 12'h008, 32'h22);
    lf_pulse(4);
    apb(1'b0, OFS_SYNC_BUSY, 32'h0);
    `CHK(rd, 32'h5)
    `CHK({lf_values[95:64], lf_values[31:0]}, 64'h0)
    apb(1'b1, OFS_UPDATE_HOLD, 32'h0);
    lf_pulse(int'(SYNC_TICKS));
    `CHK({lf_values[95:64], lf_values[31:0]}, {32'h22, 32'h11})
    apb(1'b0, OFS_STAGE_BASE + 12'h008, 32'h0);
    `CHK(rd, 32'h22)
    close_out();
  end
endmodule
